// [rtl/ccd_pkg.sv]
// Package: register map, field layout and config carrier for the dividers
package ccd_pkg;
  localparam int CCD_NSTG = 7;
  localparam int CCD_NREG = 19;
  localparam int CCD_AW = 12;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] CCD_IDX_DIV0_COUNTS = 10'h190;
  localparam logic [9:0] CCD_IDX_DIV0_PHASE = 10'h191;
  localparam logic [9:0] CCD_IDX_DIV0_CTRL = 10'h192;
  localparam logic [9:0] CCD_IDX_DIV1_COUNTS = 10'h193;
  localparam logic [9:0] CCD_IDX_DIV1_PHASE = 10'h194;
  localparam logic [9:0] CCD_IDX_DIV1_CTRL = 10'h195;
  localparam logic [9:0] CCD_IDX_DIV2_COUNTS = 10'h196;
  localparam logic [9:0] CCD_IDX_DIV2_PHASE = 10'h197;
  localparam logic [9:0] CCD_IDX_DIV2_CTRL = 10'h198;
  localparam logic [9:0] CCD_IDX_DIV3_S1_COUNTS = 10'h199;
  localparam logic [9:0] CCD_IDX_DIV3_S2_COUNTS = 10'h19b;
  localparam logic [9:0] CCD_IDX_DIV3_BYPASS = 10'h19c;
  localparam logic [9:0] CCD_IDX_DIV3_DUTY = 10'h19d;
  localparam logic [9:0] CCD_IDX_DIV4_S1_COUNTS = 10'h19e;
  localparam logic [9:0] CCD_IDX_DIV4_S2_COUNTS = 10'h1a0;
  localparam logic [9:0] CCD_IDX_DIV4_BYPASS = 10'h1a1;
  localparam logic [9:0] CCD_IDX_DIV4_DUTY = 10'h1a2;
  localparam logic [9:0] CCD_IDX_BOUT_EN = 10'h1a3;
  localparam logic [9:0] CCD_IDX_STATUS = 10'h1a4;
  // Field positions
  localparam int CCD_LO_MSB = 7;
  localparam int CCD_LO_LSB = 4;
  localparam int CCD_HI_MSB = 3;
  localparam int CCD_HI_LSB = 0;
  localparam int CCD_BEGIN_HIGH_BIT = 4;
  localparam int CCD_BYPASS_BIT = 7;
  localparam int CCD_DUTY_OFF_BIT = 0;
  localparam int CCD_DIRECT_BIT = 1;
  localparam int CCD_S1_BYPASS_BIT = 4;
  localparam int CCD_S2_BYPASS_BIT = 5;
  localparam logic [7:0] CCD_REG_RESET = 8'h00;
  localparam logic [5:0] CCD_PHASE_WRAP = 6'h10;
  localparam logic [5:0] CCD_PHASE_MAX_SHORT = 6'h0f;

  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
    logic byp;
    logic duty_fix_off;
    logic begin_high;
    logic [3:0] coarse_delay;
  } ccd_stage_cfg_t;
endpackage

// [rtl/ccd_top.sv]
// Channel clock dividers with duty fix and coarse phase, APB registers
//
// How it works
// - Duty fix is on after reset; duty_fix_off turns it off per channel.
// - Without bypass or fix, high lasts hi+1 of hi+lo+2 input cycles.
// - Prescaled bypass duty follows the prescaler, with or without fix.
// - Prescaled bypass with fix passes the prescaler's own duty.
// - Odd division with lo = hi+1 and fix stretches high by the input's high time.
// - Bypass passes input; odd fixed division gives (N+1+X)/(2N+3).
// - Direct routing sends the raw input straight to the output.
// - Coarse delay postpones the first rising edge by whole cycles.
// - Phase = 16*begin_high+coarse_delay; >=16 adds lo+1 minus 16.
// - Dividers 0-2 use count and phase registers at fixed indexes.
// - Each count field holds the cycle count minus one.
// - Dividers 3 and 4 are two cascaded stages, product up to 1024.
// - Cascade bypass selects division 1, stage one, stage two, or the product.
// - Cascade counts, stage bypass and duty_fix_off at fixed indexes.
// - One duty_fix_off bit controls both stages of a cascade.
// - Single-ended B outputs stay off after reset until enabled.
// - Without the odd fix, divider drives high hi+1 cycles, then low lo+1 cycles.
// - Bypassed divider passes input and its counter stays idle.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module ccd_top
  import ccd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CCD_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dist_in,
  input wire logic sync_req_n,
  output logic [2:0] ch_out,
  output logic [1:0] cmos_a,
  output logic [1:0] cmos_b
);

  // Register slot for a byte address, or CCD_NREG when unmapped or misaligned
  function automatic logic [4:0] slot_of(input logic [CCD_AW-1:0] a);
    logic [4:0] s;
    s = 5'(CCD_NREG);
    if (a[1:0] == 2'b00)
    begin
      case (a[CCD_AW-1:2])
        CCD_IDX_DIV0_COUNTS: s = 5'd0;
        CCD_IDX_DIV0_PHASE: s = 5'd1;
        CCD_IDX_DIV0_CTRL: s = 5'd2;
        CCD_IDX_DIV1_COUNTS: s = 5'd3;
        CCD_IDX_DIV1_PHASE: s = 5'd4;
        CCD_IDX_DIV1_CTRL: s = 5'd5;
        CCD_IDX_DIV2_COUNTS: s = 5'd6;
        CCD_IDX_DIV2_PHASE: s = 5'd7;
        CCD_IDX_DIV2_CTRL: s = 5'd8;
        CCD_IDX_DIV3_S1_COUNTS: s = 5'd9;
        CCD_IDX_DIV3_S2_COUNTS: s = 5'd10;
        CCD_IDX_DIV3_BYPASS: s = 5'd11;
        CCD_IDX_DIV3_DUTY: s = 5'd12;
        CCD_IDX_DIV4_S1_COUNTS: s = 5'd13;
        CCD_IDX_DIV4_S2_COUNTS: s = 5'd14;
        CCD_IDX_DIV4_BYPASS: s = 5'd15;
        CCD_IDX_DIV4_DUTY: s = 5'd16;
        CCD_IDX_BOUT_EN: s = 5'd17;
        CCD_IDX_STATUS: s = 5'd18;
        default: s = 5'(CCD_NREG);
      endcase
    end
    return s;
  endfunction

  // Input cycles from sync to the first rising edge
  function automatic logic [5:0] phase_dly(input ccd_stage_cfg_t c);
    logic [5:0] phi;
    phi = {1'b0, c.begin_high, c.coarse_delay};
    if (phi <= CCD_PHASE_MAX_SHORT)
      return phi;
    else
      return phi - CCD_PHASE_WRAP + {2'b00, c.lo} + 6'd1;
  endfunction

  logic [7:0] regs_r [CCD_NREG-1];
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [4:0] slot;
  logic wr_fire;
  logic [2:0] direct;
  logic [6:0] status_v;

  assign slot = slot_of(paddr);
  // Writes land only at the edge where the master sees pready high
  assign wr_fire = psel & penable & pready_r & pwrite;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r &
                   ((slot == 5'(CCD_NREG)) | (pwrite & (slot == 5'd18)));
      if (psel & penable & ~pready_r & ~pwrite)
      begin
        if (slot < 5'(CCD_NREG - 1))
          prdata_r <= {24'h00_0000, regs_r[slot]};
        else if (slot == 5'd18)
          prdata_r <= {25'h000_0000, status_v};
        else
          prdata_r <= 32'h0000_0000;
      end
    end
  end

  // All fields start at zero, so duty fix is on and B outputs are off
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < CCD_NREG - 1; i++)
        regs_r[i] <= CCD_REG_RESET;
    end
    else if (wr_fire && slot < 5'(CCD_NREG - 1))
      regs_r[slot] <= pwdata[7:0];
  end

  // Pin synchronisers; the first flop feeds only the second
  logic [1:0] din_q;
  logic [1:0] sync_q;
  logic in_s;
  logic sync_prev_r;
  logic sync_pend_r;
  logic sync_p;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      din_q <= 2'b00;
      sync_q <= 2'b11;
      sync_prev_r <= 1'b1;
      sync_pend_r <= 1'b1;
    end
    else
    begin
      din_q <= {din_q[0], dist_in};
      sync_q <= {sync_q[0], sync_req_n};
      sync_prev_r <= sync_q[1];
      sync_pend_r <= 1'b0;
    end
  end

  assign in_s = din_q[1];
  // Power-up sync right after reset, then every falling edge of the pin
  assign sync_p = sync_pend_r | (sync_prev_r & ~sync_q[1]);

  ccd_stage_cfg_t cfg [CCD_NSTG];
  logic stg_in [CCD_NSTG];
  logic stg_so [CCD_NSTG];
  logic out_r [CCD_NSTG];
  logic ext_r [CCD_NSTG];
  logic arm_r [CCD_NSTG];
  logic prev_r [CCD_NSTG];
  logic [4:0] cnt_r [CCD_NSTG];
  logic [5:0] dly_r [CCD_NSTG];

  // Stages 0-2 single dividers; 3/4 are divider 3, 5/6 divider 4
  for (genvar k = 0; k < 3; k++)
  begin : g_single
    assign cfg[k] = '{
      hi: regs_r[3*k][CCD_HI_MSB:CCD_HI_LSB],
      lo: regs_r[3*k][CCD_LO_MSB:CCD_LO_LSB],
      byp: regs_r[3*k+1][CCD_BYPASS_BIT],
      duty_fix_off: regs_r[3*k+2][CCD_DUTY_OFF_BIT],
      begin_high: regs_r[3*k+1][CCD_BEGIN_HIGH_BIT],
      coarse_delay: regs_r[3*k+1][3:0]};
    assign stg_in[k] = in_s;
  end

  // Cascades carry no phase offset here; only the sync restart applies
  for (genvar c = 0; c < 2; c++)
  begin : g_casc
    localparam int B = 9 + 4 * c;
    localparam int S = 3 + 2 * c;
    assign cfg[S] = '{
      hi: regs_r[B][CCD_HI_MSB:CCD_HI_LSB],
      lo: regs_r[B][CCD_LO_MSB:CCD_LO_LSB],
      byp: regs_r[B+2][CCD_S1_BYPASS_BIT],
      duty_fix_off: regs_r[B+3][CCD_DUTY_OFF_BIT],
      begin_high: 1'b0,
      coarse_delay: 4'h0};
    assign cfg[S+1] = '{
      hi: regs_r[B+1][CCD_HI_MSB:CCD_HI_LSB],
      lo: regs_r[B+1][CCD_LO_MSB:CCD_LO_LSB],
      byp: regs_r[B+2][CCD_S2_BYPASS_BIT],
      duty_fix_off: regs_r[B+3][CCD_DUTY_OFF_BIT],
      begin_high: 1'b0,
      coarse_delay: 4'h0};
    assign stg_in[S] = in_s;
    assign stg_in[S+1] = stg_so[S];
  end

  for (genvar s = 0; s < CCD_NSTG; s++)
  begin : g_stage
    logic rise;
    logic fall;
    logic fix_odd;
    assign rise = stg_in[s] & ~prev_r[s];
    assign fall = ~stg_in[s] & prev_r[s];
    assign fix_odd = ~cfg[s].duty_fix_off &
                     ({1'b0, cfg[s].lo} == {1'b0, cfg[s].hi} + 5'd1);
    // Bypass hands the input on untouched
    assign stg_so[s] = cfg[s].byp ? stg_in[s]
                                  : out_r[s];

    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        prev_r[s] <= 1'b0;
      else
        prev_r[s] <= stg_in[s];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        out_r[s] <= 1'b0;
        ext_r[s] <= 1'b0;
        arm_r[s] <= 1'b1;
        cnt_r[s] <= 5'd0;
        dly_r[s] <= 6'd0;
      end
      else if (cfg[s].byp)
      begin
        // Counter held idle, standing in for the powered-down circuit
        out_r[s] <= 1'b0;
        ext_r[s] <= 1'b0;
        arm_r[s] <= 1'b1;
        cnt_r[s] <= 5'd0;
        dly_r[s] <= 6'd0;
      end
      else if (sync_p)
      begin
        out_r[s] <= 1'b0;
        ext_r[s] <= 1'b0;
        arm_r[s] <= 1'b1;
        cnt_r[s] <= 5'd0;
        dly_r[s] <= phase_dly(cfg[s]);
      end
      else if (rise)
      begin
        if (dly_r[s] != 6'd0)
          dly_r[s] <= dly_r[s] - 6'd1;
        else if (arm_r[s])
        begin
          out_r[s] <= 1'b1;
          arm_r[s] <= 1'b0;
          cnt_r[s] <= 5'd0;
        end
        else if (out_r[s] && !ext_r[s])
        begin
          if (cnt_r[s] == {1'b0, cfg[s].hi})
          begin
            cnt_r[s] <= 5'd0;
            // Odd fixed division stays high to the next falling input edge
            if (fix_odd)
              ext_r[s] <= 1'b1;
            else
              out_r[s] <= 1'b0;
          end
          else
            cnt_r[s] <= cnt_r[s] + 5'd1;
        end
        else if (cnt_r[s] == {1'b0, cfg[s].lo})
        begin
          out_r[s] <= 1'b1;
          cnt_r[s] <= 5'd0;
        end
        else
          cnt_r[s] <= cnt_r[s] + 5'd1;
      end
      else if (fall && ext_r[s])
      begin
        out_r[s] <= 1'b0;
        ext_r[s] <= 1'b0;
      end
    end
  end

  assign direct = {regs_r[8][CCD_DIRECT_BIT], regs_r[5][CCD_DIRECT_BIT],
                   regs_r[2][CCD_DIRECT_BIT]};
  assign status_v = {cmos_b, cmos_a[1], cmos_a[0], ch_out};

  // Outputs are registered; pad drivers see one clean flop each
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ch_out <= 3'b000;
      cmos_a <= 2'b00;
      cmos_b <= 2'b00;
    end
    else
    begin
      for (int k = 0; k < 3; k++)
        ch_out[k] <= direct[k] ? in_s : stg_so[k];
      // With stage one bypassed the product collapses to stage two alone
      cmos_a[0] <= stg_so[4];
      cmos_a[1] <= stg_so[6];
      cmos_b[0] <= stg_so[4] & regs_r[17][0];
      cmos_b[1] <= stg_so[6] & regs_r[17][1];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  a_dfix_gate: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ext_r[0]) |-> $past(!cfg[0].duty_fix_off))
    else $error("duty fix stretch with fix disabled");

  a_casc_dfix: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ext_r[4]) |-> $past(!regs_r[12][CCD_DUTY_OFF_BIT]))
    else $error("cascade stretch with fix disabled");

  a_high_end: assert property (@(posedge clk) disable iff (!rstn)
    (!cfg[0].byp && !sync_p && g_stage[0].rise && dly_r[0] == 6'd0 &&
     !arm_r[0] && out_r[0] && !ext_r[0] && !g_stage[0].fix_odd &&
     cnt_r[0] == {1'b0, cfg[0].hi}) |=> !out_r[0])
    else $error("high phase did not end after hi+1 cycles");

  a_ext_fall: assert property (@(posedge clk) disable iff (!rstn)
    (ext_r[0] && g_stage[0].fall && !cfg[0].byp && !sync_p)
    |=> !out_r[0] && !ext_r[0])
    else $error("stretched high did not end at falling input");

  a_delay_low: assert property (@(posedge clk) disable iff (!rstn)
    (dly_r[0] != 6'd0) |-> !out_r[0])
    else $error("output rose before coarse delay expired");

  a_sync_phase: assert property (@(posedge clk) disable iff (!rstn)
    (sync_p && !cfg[0].byp && cfg[0].begin_high)
    |=> dly_r[0] == {2'b00, $past(cfg[0].coarse_delay)} +
        {2'b00, $past(cfg[0].lo)} + 6'd1)
     else $error("begin_high delay wrong");

  a_bypass_path: assert property (@(posedge clk) disable iff (!rstn)
    (cfg[1].byp && !direct[1]) ##1 cfg[1].byp |-> cnt_r[1] == 5'd0 &&
    ch_out[1] == $past(in_s))
    else $error("bypassed divider not passing input");

  a_direct_out: assert property (@(posedge clk) disable iff (!rstn)
    direct[2] |=> ch_out[2] == $past(in_s))
    else $error("direct route does not follow input");

  a_bout_off: assert property (@(posedge clk) disable iff (!rstn)
    !regs_r[17][1] |=> !cmos_b[1])
    else $error("B output active while disabled");

  a_sync_restart: assert property (@(posedge clk) disable iff (!rstn)
    (sync_p && !cfg[3].byp) |=> cnt_r[3] == 5'd0 && !out_r[3] && arm_r[3])
    else $error("sync did not restart counter");

endmodule

// [verif/ccd_top_tb_top.sv]
// Self-checking bench for the channel clock dividers
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("Error t=%0t got %0h exp %0h", $time, g, e); \
    end \
  end
module channel_clock_divider_dcc_phase_tb_top;
  import ccd_pkg::*;
  logic clk, rstn, psel, penable, pwrite, sync_req_n, pready, pslverr;
  logic [CCD_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] ch_out;
  logic [1:0] cmos_a, cmos_b;
  logic dist_in = 1'b0;
  int dcnt = 0;
  int dist_hi, dist_lo, errors, cmp_count;
  logic [7:0] lfsr_r;
  logic [9:0] mon_e;
  logic [9:0] exp_q[$];
  wire [6:0] outs = {cmos_b, cmos_a, ch_out};
  logic [9:0] regs [15] = '{CCD_IDX_DIV0_COUNTS, CCD_IDX_DIV0_PHASE,
    CCD_IDX_DIV1_COUNTS, CCD_IDX_DIV1_PHASE, CCD_IDX_DIV2_COUNTS,
    CCD_IDX_DIV2_PHASE, CCD_IDX_DIV3_S1_COUNTS, CCD_IDX_DIV3_S2_COUNTS,
    CCD_IDX_DIV3_BYPASS, CCD_IDX_DIV3_DUTY, CCD_IDX_DIV4_S1_COUNTS,
    CCD_IDX_DIV4_S2_COUNTS, CCD_IDX_DIV4_BYPASS, CCD_IDX_DIV4_DUTY,
    CCD_IDX_BOUT_EN};

  ccd_top u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dist_in(dist_in),
    .sync_req_n(sync_req_n), .ch_out(ch_out), .cmos_a(cmos_a),
    .cmos_b(cmos_b));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Divider input as an oversampled level; each phase lasts >= 2 clocks until the last case holds it high
  always @(posedge clk)
  begin
    dcnt <= (dcnt + 1 >= dist_hi + dist_lo) ? 0 : dcnt + 1;
    dist_in <= (dcnt < dist_hi);
  end

  // Read data and error code are judged against the oldest note
  always @(posedge clk)
    if (pready === 1'b1)
    begin
      mon_e = exp_q.pop_front();
      `CHK(pslverr, mon_e[8])
      if (mon_e[9])
        `CHK(prdata, {24'h00_0000, mon_e[7:0]})
    end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic apb(input logic wr, input logic [9:0] idx,
    input logic [7:0] wd, input logic [7:0] rd_exp, input logic err);
    exp_q.push_back({~wr, err, rd_exp});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do
      @(posedge clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sync restarts all counters so each case starts from a known phase
  task automatic do_sync;
    @(posedge clk);
    sync_req_n <= 1'b0;
    repeat (4) @(posedge clk);
    sync_req_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic wait_lvl(input int b, input logic v, inout int n);
    while (outs[b] !== v && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // Second full period is kept; the first may follow a config change
  task automatic measure(input int b, output int hi, output int lo);
    int n;
    n = 0;
    repeat (2)
    begin
      wait_lvl(b, 1'b0, n);
      wait_lvl(b, 1'b1, n);
      hi = 0;
      lo = 0;
      for (; outs[b] === 1'b1 && n < 2000; n++, hi++)
        @(posedge clk);
      for (; outs[b] === 1'b0 && n < 2000; n++, lo++)
        @(posedge clk);
    end
  endtask

  task automatic run_case(input logic [9:0] idx, input logic [7:0] v,
    input int b, input int eh, input int el, input string nm);
    int hi, lo;
    apb(1'b1, idx, v, 8'h00, 1'b0);
    do_sync();
    measure(b, hi, lo);
    `CHK(hi, eh)
    `CHK(lo, el)
    $display("Test %s done", nm);
  endtask

  task automatic phase_case(input logic [7:0] ph, input int m);
    int n, d;
    d = {ph[4], ph[3:0]};
    d = (d <= 15) ? d : d - 16 + m + 1;
    apb(1'b1, CCD_IDX_DIV0_PHASE, ph, 8'h00, 1'b0);
    do_sync();
    n = 0;
    wait_lvl(1, 1'b0, n);
    wait_lvl(1, 1'b1, n);
    n = 0;
    wait_lvl(0, 1'b0, n);
    wait_lvl(0, 1'b1, n);
    `CHK(n, d * 4)
    $display("Test phase done");
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sync_req_n = 1'b1;
    dist_hi = 2;
    dist_lo = 2;
    errors = 0;
    cmp_count = 0;
    lfsr_r = 8'h30;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    foreach (regs[i])
      apb(1'b0, regs[i], 8'h00, CCD_REG_RESET, 1'b0);
    foreach (regs[i])
    begin
      lfsr_r = lfsr(lfsr_r);
      // Stage one is never bypassed alone while stage two runs
      if (regs[i] == CCD_IDX_DIV3_BYPASS || regs[i] == CCD_IDX_DIV4_BYPASS)
        lfsr_r[CCD_S2_BYPASS_BIT] |= lfsr_r[CCD_S1_BYPASS_BIT];
      apb(1'b1, regs[i], lfsr_r, 8'h00, 1'b0);
      apb(1'b0, regs[i], 8'h00, lfsr_r, 1'b0);
      apb(1'b1, regs[i], 8'h00, 8'h00, 1'b0);
    end
    apb(1'b0, 10'h19a, 8'h00, 8'h00, 1'b1);
    apb(1'b1, CCD_IDX_STATUS, 8'hff, 8'h00, 1'b1);
    $display("Test registers done");
    run_case(CCD_IDX_DIV4_S1_COUNTS, 8'h00, 4, 8, 8, "casc");
    apb(1'b1, CCD_IDX_DIV0_COUNTS, 8'h21, 8'h00, 1'b0);
    run_case(CCD_IDX_DIV0_CTRL, 8'h01, 0, 2 * 4, 3 * 4, "raw");
    run_case(CCD_IDX_DIV0_CTRL, 8'h00, 0, 10, 10, "fix");
    dist_hi = 2;
    dist_lo = 4;
    run_case(CCD_IDX_DIV0_CTRL, 8'h00, 0, 2 * 6 + 2, 3 * 6 - 2, "x");
    run_case(CCD_IDX_DIV1_PHASE, 8'h80, 1, 2, 4, "byp");
    run_case(CCD_IDX_DIV2_CTRL, 8'h02, 2, 2, 4, "direct");
    dist_lo = 2;
    apb(1'b1, CCD_IDX_DIV3_S2_COUNTS, 8'h21, 8'h00, 1'b0);
    run_case(CCD_IDX_DIV3_DUTY, 8'h01, 3, 2 * 8, 3 * 8, "prod");
    run_case(CCD_IDX_DIV3_DUTY, 8'h00, 3, 20, 20, "cfix");
    `CHK(cmos_b, 2'b00)
    run_case(CCD_IDX_DIV3_BYPASS, 8'h20, 3, 4, 4, "s2byp");
    run_case(CCD_IDX_DIV3_BYPASS, 8'h30, 3, 2, 2, "s12byp");
    run_case(CCD_IDX_BOUT_EN, 8'h01, 5, 2, 2, "bout");
    apb(1'b1, CCD_IDX_DIV0_COUNTS, 8'h33, 8'h00, 1'b0);
    apb(1'b1, CCD_IDX_DIV1_COUNTS, 8'h33, 8'h00, 1'b0);
    apb(1'b1, CCD_IDX_DIV1_PHASE, 8'h00, 8'h00, 1'b0);
    phase_case(8'h03, 3);
    phase_case(8'h12, 3);
    // Input held high: no more rises, so after a sync the outputs freeze
    dist_lo = 0;
    repeat (8) @(posedge clk);
    do_sync();
    apb(1'b0, CCD_IDX_STATUS, 8'h00, 8'h2c, 1'b0);
    $display("Test status done");
    tally_and_finish();
  end
endmodule
